/* core/tssp_defines.vh */
// Register offsets, field positions, reset values and codes of the timer sync/stop/PWM logic.
`ifndef TSSP_DEFINES_VH
`define TSSP_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TSSP_OFF_IRQ_CTRL_A      8'h00
`define TSSP_OFF_IRQ_CTRL_B      8'h04
`define TSSP_OFF_T_ONE_CTRL      8'h08
`define TSSP_OFF_T_THREE_CTRL    8'h0c
`define TSSP_OFF_T_FOUR_CTRL     8'h10
`define TSSP_OFF_PERIOD_MEAS     8'h14
`define TSSP_OFF_PIN_CTRL        8'h18
`define TSSP_OFF_LOW_RELOAD      8'h1c
`define TSSP_OFF_HIGH_RELOAD     8'h20
`define TSSP_OFF_REQ_FLAGS       8'h24
`define TSSP_OFF_STATUS          8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TSSP_IRQ_SYNC_SEL        0
`define TSSP_IRQ_BOTH_EDGES      1
`define TSSP_IRQ_RISING          2
`define TSSP_TMR_PIN_SRC         0
`define TSSP_T_ONE_OUT_T2        1
`define TSSP_TMR_RUN             2
`define TSSP_TMR_AUTO_STOP       3
`define TSSP_T4_SRC_SEL          0
`define TSSP_T4_RUN              1
`define TSSP_T4_HIGH_EXT         2
`define TSSP_T4_PWM_OUT_EN       3
`define TSSP_MEAS_ACTIVE         2
`define TSSP_PIN_A_OUTPUT        0
`define TSSP_PIN_PWM_AUTO        1
`define TSSP_PIN_A_FALL          2
`define TSSP_PIN_B_FALL          3

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define TSSP_RST_CTRL            4'h0
`define TSSP_RST_RELOAD          8'hff
`define TSSP_RST_FLAGS           4'h0
`define TSSP_RESP_OKAY           2'h0
`define TSSP_RESP_SLVERR         2'h2

`endif

/* core/tssp_timer_ctrl.v */
// Timer start synchronisation, auto-stop, counter pins, timer 4 PWM and request flags.
//
// Notes on behaviour
// - Irq control A bit 0 syncs timer 1.
// - Irq control B bit 0 syncs timer 3.
// - Synchroniser sets on the interrupt-valid pin waveform.
// - Synchroniser holds until deselect, reset, or auto-stop.
// - Timer 1 control bit 3 enables auto-stop.
// - Timer 3 control bit 3 enables auto-stop.
// - Pin A: timer 1 input or underflow/2 output.
// - Pin B: timer 3 input or PWM output.
// - Pin control bits 2/3 pick counted edge.
// - PWM reloads alternately low then high intervals.
// - Extension adds half source period to high.
// - Timer 3 underflow toggles PWM validity; stop cancels.
// - Disabling auto-control keeps current validity state.
// - Stop during high interval waits for underflow.
// - Underflow sets flag; taken or skip clears.
// - During measurement timer 1 flag marks completion.
// - Timers 1 and 3 count from first rising edge.
// - Timer 4 counts from rise after first fall.
// - Timer 4 starts after load, source, run bit.
`timescale 1ns/1ps
`include "tssp_defines.vh"

module tssp_timer_ctrl (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// AXI4-Lite write channels
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	// AXI4-Lite read channels
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	// External interrupt pins
	input  wire        extIrqPinA,
	input  wire        extIrqPinB,
	// Counter pin A
	input  wire        counterPinAIn,
	output reg         counterPinAOut,
	output reg         counterPinAOe,
	// Counter pin B
	input  wire        counterPinBIn,
	output reg         counterPinBOut,
	output reg         counterPinBOe,
	// Timer cores
	input  wire        tOneSrc,
	input  wire        tThreeSrc,
	input  wire        tOneUnderflow,
	input  wire        tTwoUnderflow,
	input  wire        tThreeUnderflow,
	input  wire        measDone,
	input  wire        tFourSrcA,
	input  wire        tFourSrcB,
	output reg         tOneCountPulse,
	output reg         tThreeCountPulse,
	output reg         tFourUnderflow,
	// Request flags
	input  wire [3:0]  flagAck,
	output reg  [3:0]  reqFlags
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function edgeHit;
		input cur;
		input prev;
		input fallSel;
		begin
			edgeHit = fallSel ? (prev & ~cur) : (cur & ~prev);
		end
	endfunction

	function irqValid;
		input       cur;
		input       prev;
		input [3:0] ctrl;
		begin
			if (ctrl[`TSSP_IRQ_BOTH_EDGES]) begin
				irqValid = cur ^ prev;
			end else begin
				irqValid = edgeHit(cur, prev, ~ctrl[`TSSP_IRQ_RISING]);
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	reg [3:0] pinMeta_ff;
	reg [3:0] pinSync_ff;
	reg [3:0] pinPrev_ff;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_ff <= 4'h0;
			pinSync_ff <= 4'h0;
			pinPrev_ff <= 4'h0;
		end else begin
			pinMeta_ff <= {counterPinBIn, counterPinAIn, extIrqPinB, extIrqPinA};
			pinSync_ff <= pinMeta_ff;
			pinPrev_ff <= pinSync_ff;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [3:0] irqCtrlA_ff;
	reg [3:0] irqCtrlB_ff;
	reg [3:0] tOneCtrl_ff;
	reg [3:0] tThreeCtrl_ff;
	reg [3:0] tFourCtrl_ff;
	reg [3:0] periodMeasCtrl_ff;
	reg [3:0] pinCtrl_ff;
	reg [7:0] lowReload_ff;
	reg [7:0] highReload_ff;
	reg       syncA_ff;
	reg       syncB_ff;
	reg       pwmValid_ff;
	reg       pwmHigh_ff;
	reg       tFourActive_ff;
	reg       tFourArmed_ff;
	reg       extPend_ff;
	reg [7:0] tFourCnt_ff;
	reg       tFourSrcPrev_ff;
	reg       tFourPhase_ff;
	reg       pinADiv_ff;

	reg [7:0] awAddr_ff;
	reg       awHeld_ff;
	reg [7:0] wData_ff;
	reg       wLane_ff;
	reg       wHeld_ff;

	wire doWrite = awHeld_ff & wHeld_ff & ~bvalid;
	wire wrEn    = doWrite & wLane_ff;
	wire wrIrqA  = wrEn & (awAddr_ff == `TSSP_OFF_IRQ_CTRL_A);
	wire wrIrqB  = wrEn & (awAddr_ff == `TSSP_OFF_IRQ_CTRL_B);
	wire wrT1    = wrEn & (awAddr_ff == `TSSP_OFF_T_ONE_CTRL);
	wire wrT3    = wrEn & (awAddr_ff == `TSSP_OFF_T_THREE_CTRL);
	wire wrT4    = wrEn & (awAddr_ff == `TSSP_OFF_T_FOUR_CTRL);
	wire wrMeas  = wrEn & (awAddr_ff == `TSSP_OFF_PERIOD_MEAS);
	wire wrPin   = wrEn & (awAddr_ff == `TSSP_OFF_PIN_CTRL);
	wire wrLow   = wrEn & (awAddr_ff == `TSSP_OFF_LOW_RELOAD);
	wire wrHigh  = wrEn & (awAddr_ff == `TSSP_OFF_HIGH_RELOAD);
	wire wrFlags = wrEn & (awAddr_ff == `TSSP_OFF_REQ_FLAGS);

	function mapped;
		input [7:0] addr;
		begin
			mapped = (addr[1:0] == 2'h0) && (addr <= `TSSP_OFF_STATUS);
		end
	endfunction

	// ----------------------------------------------------------------
	// Start synchronisers and auto-stop
	// ----------------------------------------------------------------
	wire selA      = irqCtrlA_ff[`TSSP_IRQ_SYNC_SEL];
	wire selB      = irqCtrlB_ff[`TSSP_IRQ_SYNC_SEL];
	wire autoStopA = selA & tOneCtrl_ff[`TSSP_TMR_AUTO_STOP] & tOneUnderflow;
	wire autoStopB = selB & tThreeCtrl_ff[`TSSP_TMR_AUTO_STOP] & tThreeUnderflow;
	wire setA      = selA & irqValid(pinSync_ff[0], pinPrev_ff[0], irqCtrlA_ff);
	wire setB      = selB & irqValid(pinSync_ff[1], pinPrev_ff[1], irqCtrlB_ff);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_ff <= 1'b0;
			syncB_ff <= 1'b0;
		end else begin
			if (!selA) begin
				syncA_ff <= 1'b0;
			end else if (setA) begin
				syncA_ff <= 1'b1;
			end else if (autoStopA) begin
				syncA_ff <= 1'b0;
			end
			if (!selB) begin
				syncB_ff <= 1'b0;
			end else if (setB) begin
				syncB_ff <= 1'b1;
			end else if (autoStopB) begin
				syncB_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Count sources for timers 1 and 3
	// ----------------------------------------------------------------
	// Edges are detected on the ungated source and the gate is applied after, so the first counted edge is
	// the first rising edge after the gate opens, never one already past.
	wire pwmOutEn   = tFourCtrl_ff[`TSSP_T4_PWM_OUT_EN];
	wire pinAInput  = ~pinCtrl_ff[`TSSP_PIN_A_OUTPUT];
	wire tOneGate   = tOneCtrl_ff[`TSSP_TMR_RUN] & (~selA | syncA_ff);
	wire tThreeGate = tThreeCtrl_ff[`TSSP_TMR_RUN] & (~selB | syncB_ff);
	reg  tOneSrcPrev_ff;
	reg  tThreeSrcPrev_ff;
	wire tOnePinHit = pinAInput & edgeHit(pinSync_ff[2], pinPrev_ff[2],
		pinCtrl_ff[`TSSP_PIN_A_FALL]);
	wire tThreePinHit = ~pwmOutEn & edgeHit(pinSync_ff[3], pinPrev_ff[3],
		pinCtrl_ff[`TSSP_PIN_B_FALL]);
	wire tOneHit = tOneCtrl_ff[`TSSP_TMR_PIN_SRC] ? tOnePinHit :
		(tOneSrc & ~tOneSrcPrev_ff);
	wire tThreeHit = tThreeCtrl_ff[`TSSP_TMR_PIN_SRC] ? tThreePinHit :
		(tThreeSrc & ~tThreeSrcPrev_ff);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tOneSrcPrev_ff   <= 1'b1;
			tThreeSrcPrev_ff <= 1'b1;
			tOneCountPulse   <= 1'b0;
			tThreeCountPulse <= 1'b0;
		end else begin
			tOneSrcPrev_ff   <= tOneSrc;
			tThreeSrcPrev_ff <= tThreeSrc;
			tOneCountPulse   <= tOneGate & tOneHit;
			tThreeCountPulse <= tThreeGate & tThreeHit;
		end
	end

	// ----------------------------------------------------------------
	// Timer 4 and PWM
	// ----------------------------------------------------------------
	wire tFourRunBit = tFourCtrl_ff[`TSSP_T4_RUN];
	wire tFourSrc    = tFourCtrl_ff[`TSSP_T4_SRC_SEL] ? tFourSrcB : tFourSrcA;
	wire tFourRise   = tFourSrc & ~tFourSrcPrev_ff;
	wire tFourFall   = ~tFourSrc & tFourSrcPrev_ff;
	wire highExt     = tFourCtrl_ff[`TSSP_T4_HIGH_EXT] & pwmOutEn;
	// After an extended high interval the count moves to the other source edge,
	// so the half period is added once and the low interval keeps its length.
	wire tFourTick   = tFourPhase_ff ? tFourFall : tFourRise;
	wire tFourHalf   = tFourPhase_ff ? tFourRise : tFourFall;
	wire zeroHit     = tFourActive_ff & tFourArmed_ff & ~extPend_ff & tFourTick &
		(tFourCnt_ff == 8'h00);
	wire tFourUf     = (zeroHit & ~(pwmHigh_ff & highExt)) |
		(tFourActive_ff & extPend_ff & tFourHalf);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tFourActive_ff  <= 1'b0;
			tFourArmed_ff   <= 1'b0;
			extPend_ff      <= 1'b0;
			pwmHigh_ff      <= 1'b0;
			tFourCnt_ff     <= `TSSP_RST_RELOAD;
			tFourSrcPrev_ff <= 1'b0;
			tFourPhase_ff   <= 1'b0;
			tFourUnderflow  <= 1'b0;
		end else begin
			tFourSrcPrev_ff <= tFourSrc;
			tFourUnderflow  <= tFourUf;
			if (!tFourActive_ff) begin
				extPend_ff    <= 1'b0;
				tFourArmed_ff <= 1'b0;
				pwmHigh_ff    <= 1'b0;
				tFourPhase_ff <= 1'b0;
				if (wrLow) begin
					tFourCnt_ff <= wData_ff;
				end
				if (tFourRunBit) begin
					tFourActive_ff <= 1'b1;
				end
			end else if (!tFourRunBit && !(pwmOutEn && pwmHigh_ff) && !tFourUf) begin
				tFourActive_ff <= 1'b0;
			end else begin
				if (!tFourArmed_ff && tFourFall) begin
					tFourArmed_ff <= 1'b1;
				end
				if (tFourUf) begin
					extPend_ff <= 1'b0;
					if (extPend_ff) begin
						tFourPhase_ff <= ~tFourPhase_ff;
					end
					if (!tFourRunBit) begin
						tFourActive_ff <= 1'b0;
					end
					if (pwmOutEn) begin
						pwmHigh_ff  <= ~pwmHigh_ff;
						tFourCnt_ff <= pwmHigh_ff ? lowReload_ff : highReload_ff;
					end else begin
						pwmHigh_ff  <= 1'b0;
						tFourCnt_ff <= lowReload_ff;
					end
				end else if (zeroHit) begin
					extPend_ff <= 1'b1;
				end else if (tFourArmed_ff && tFourTick && !extPend_ff) begin
					tFourCnt_ff <= tFourCnt_ff - 8'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// PWM validity and pins
	// ----------------------------------------------------------------
	wire pwmAuto = pinCtrl_ff[`TSSP_PIN_PWM_AUTO] & tThreeCtrl_ff[`TSSP_TMR_RUN];
	wire divSrc  = tOneCtrl_ff[`TSSP_T_ONE_OUT_T2] ? tTwoUnderflow : tOneUnderflow;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwmValid_ff    <= 1'b1;
			pinADiv_ff     <= 1'b0;
			counterPinAOut <= 1'b0;
			counterPinAOe  <= 1'b0;
			counterPinBOut <= 1'b0;
			counterPinBOe  <= 1'b0;
		end else begin
			if (pwmAuto && tThreeUnderflow) begin
				pwmValid_ff <= ~pwmValid_ff;
			end
			if (divSrc) begin
				pinADiv_ff <= ~pinADiv_ff;
			end
			counterPinAOut <= pinADiv_ff;
			counterPinAOe  <= ~pinAInput;
			counterPinBOut <= pwmHigh_ff & tFourActive_ff & pwmValid_ff;
			counterPinBOe  <= pwmOutEn;
		end
	end

	// ----------------------------------------------------------------
	// Request flags
	// ----------------------------------------------------------------
	// A set in the same cycle as a clear wins, so no underflow is lost.
	wire       measActive = periodMeasCtrl_ff[`TSSP_MEAS_ACTIVE];
	wire       tOneEvent  = measActive ? measDone : tOneUnderflow;
	wire [3:0] flagSet    = {tFourUf, tThreeUnderflow, tTwoUnderflow, tOneEvent};
	wire [3:0] flagClr    = flagAck | (wrFlags ? wData_ff[3:0] : 4'h0);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reqFlags <= `TSSP_RST_FLAGS;
		end else begin
			reqFlags <= (reqFlags & ~flagClr) | flagSet;
		end
	end

	// ----------------------------------------------------------------
	// Control register writes
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqCtrlA_ff       <= `TSSP_RST_CTRL;
			irqCtrlB_ff       <= `TSSP_RST_CTRL;
			tOneCtrl_ff       <= `TSSP_RST_CTRL;
			tThreeCtrl_ff     <= `TSSP_RST_CTRL;
			tFourCtrl_ff      <= `TSSP_RST_CTRL;
			periodMeasCtrl_ff <= `TSSP_RST_CTRL;
			pinCtrl_ff        <= `TSSP_RST_CTRL;
			lowReload_ff      <= `TSSP_RST_RELOAD;
			highReload_ff     <= `TSSP_RST_RELOAD;
		end else begin
			if (wrIrqA) begin
				irqCtrlA_ff <= wData_ff[3:0];
			end
			if (wrIrqB) begin
				irqCtrlB_ff <= wData_ff[3:0];
			end
			if (wrT1) begin
				tOneCtrl_ff <= wData_ff[3:0];
			end else if (autoStopA) begin
				tOneCtrl_ff[`TSSP_TMR_AUTO_STOP] <= 1'b0;
			end
			if (wrT3) begin
				tThreeCtrl_ff <= wData_ff[3:0];
			end else if (autoStopB) begin
				tThreeCtrl_ff[`TSSP_TMR_AUTO_STOP] <= 1'b0;
			end
			if (wrT4) begin
				tFourCtrl_ff <= wData_ff[3:0];
			end
			if (wrMeas) begin
				periodMeasCtrl_ff <= wData_ff[3:0];
			end
			if (wrPin) begin
				pinCtrl_ff <= wData_ff[3:0];
			end
			if (wrLow) begin
				lowReload_ff <= wData_ff;
			end
			if (wrHigh) begin
				highReload_ff <= wData_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	reg [31:0] readMux;

	always @* begin
		readMux = 32'h00000000;
		case (araddr)
			`TSSP_OFF_IRQ_CTRL_A:   readMux[3:0] = irqCtrlA_ff;
			`TSSP_OFF_IRQ_CTRL_B:   readMux[3:0] = irqCtrlB_ff;
			`TSSP_OFF_T_ONE_CTRL:   readMux[3:0] = tOneCtrl_ff;
			`TSSP_OFF_T_THREE_CTRL: readMux[3:0] = tThreeCtrl_ff;
			`TSSP_OFF_T_FOUR_CTRL:  readMux[3:0] = tFourCtrl_ff;
			`TSSP_OFF_PERIOD_MEAS:  readMux[3:0] = periodMeasCtrl_ff;
			`TSSP_OFF_PIN_CTRL:     readMux[3:0] = pinCtrl_ff;
			`TSSP_OFF_LOW_RELOAD:   readMux[7:0] = lowReload_ff;
			`TSSP_OFF_HIGH_RELOAD:  readMux[7:0] = highReload_ff;
			`TSSP_OFF_REQ_FLAGS:    readMux[3:0] = reqFlags;
			`TSSP_OFF_STATUS:       readMux[15:0] = {tFourCnt_ff, 2'h0, extPend_ff,
				tFourActive_ff, pwmHigh_ff, pwmValid_ff, syncB_ff, syncA_ff};
			default:                readMux = 32'h00000000;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			awHeld_ff <= 1'b0;
			wHeld_ff  <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff  <= 8'h00;
			wLane_ff  <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= `TSSP_RESP_OKAY;
			arready   <= 1'b1;
			rvalid    <= 1'b0;
			rdata     <= 32'h00000000;
			rresp     <= `TSSP_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awAddr_ff <= awaddr;
				awHeld_ff <= 1'b1;
				awready   <= 1'b0;
			end
			if (wvalid && wready) begin
				wData_ff <= wdata[7:0];
				wLane_ff <= wstrb[0];
				wHeld_ff <= 1'b1;
				wready   <= 1'b0;
			end
			if (doWrite) begin
				awHeld_ff <= 1'b0;
				wHeld_ff  <= 1'b0;
				awready   <= 1'b1;
				wready    <= 1'b1;
				bvalid    <= 1'b1;
				bresp     <= mapped(awAddr_ff) ? `TSSP_RESP_OKAY : `TSSP_RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= readMux;
				rresp   <= mapped(araddr) ? `TSSP_RESP_OKAY : `TSSP_RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule // tssp_timer_ctrl

/* bench/tssp_timer_ctrl_chk.sv */
// Port checker of the timer sync, stop and PWM logic.
`timescale 1ns/1ps
module tssp_timer_ctrl_chk (
	// Clock and reset
	input wire        clk,
	input wire        rst_n,
	// Bus handshakes
	input wire        awvalid,
	input wire        awready,
	input wire        wvalid,
	input wire        wready,
	input wire        bvalid,
	input wire        bready,
	input wire [1:0]  bresp,
	input wire        arvalid,
	input wire        arready,
	input wire        rvalid,
	input wire        rready,
	input wire [31:0] rdata,
	// Timer side
	input wire        tOneCountPulse,
	input wire        tThreeCountPulse,
	input wire        tOneUnderflow,
	input wire        tTwoUnderflow,
	input wire        tThreeUnderflow,
	input wire        counterPinAOut,
	input wire        counterPinAOe,
	input wire [3:0]  flagAck,
	input wire [3:0]  reqFlags
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	wr_resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rd_data_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	rd_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
		else $error("write answer late");
	one_pulse_a: assert property (tOneCountPulse |=> !tOneCountPulse)
		else $error("timer 1 count pulse too long");
	three_pulse_a: assert property (tThreeCountPulse |=> !tThreeCountPulse)
		else $error("timer 3 count pulse too long");
	flag_set_a: assert property (tThreeUnderflow |=> reqFlags[2])
		else $error("timer 3 flag not set");
	flag_clear_a: assert property (reqFlags[2] && flagAck[2] && !tThreeUnderflow |=> !reqFlags[2])
		else $error("timer 3 flag not cleared");
	pin_toggle_a: assert property (counterPinAOe && $past(counterPinAOe)
		&& $changed(counterPinAOut) |-> $past(tOneUnderflow) || $past(tTwoUnderflow)
		|| $past(tOneUnderflow, 2) || $past(tTwoUnderflow, 2))
		else $error("pin A output moved without underflow");
endmodule // tssp_timer_ctrl_chk

bind tssp_timer_ctrl tssp_timer_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
	.rdata(rdata), .tOneCountPulse(tOneCountPulse), .tThreeCountPulse(tThreeCountPulse),
	.tOneUnderflow(tOneUnderflow), .tTwoUnderflow(tTwoUnderflow),
	.tThreeUnderflow(tThreeUnderflow), .counterPinAOut(counterPinAOut),
	.counterPinAOe(counterPinAOe), .flagAck(flagAck), .reqFlags(reqFlags));

/* bench/tssp_pin_partner.sv */
// Model of the pulse sources and loads on the two counter pins.
`timescale 1ns/1ps
module tssp_pin_partner (
	// Levels of the external sources
	input  wire srcA,
	input  wire srcB,
	// Design side of the pins
	input  wire outA,
	input  wire oeA,
	input  wire outB,
	input  wire oeB,
	// Resolved wire levels
	output wire pinA,
	output wire pinB
);
	// Sources drive through a series resistor, so the design wins while it drives.
	assign pinA = oeA ? outA : srcA;
	assign pinB = oeB ? outB : srcB;
endmodule // tssp_pin_partner

/* bench/tssp_timer_ctrl_bench.sv */
// Testbench of the timer sync, stop and PWM logic.
`timescale 1ns/1ps
`include "tssp_defines.vh"
module tssp_timer_ctrl_bench;
	logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, measDone, src, p1, p3, p4;
	logic        pinASrc, pinBSrc, pinA, pinB, aOut, aOe, bOut, bOe;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  flagAck, reqFlags, ufl;
	logic [1:0]  bresp, rresp, rr, ext, div;
	int          nP [3];
	int          n_errors, n_compared, h, l, i;

	tssp_timer_ctrl i_dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.extIrqPinA(ext[0]), .extIrqPinB(ext[1]), .counterPinAIn(pinA), .counterPinAOut(aOut),
		.counterPinAOe(aOe), .counterPinBIn(pinB), .counterPinBOut(bOut), .counterPinBOe(bOe),
		.tOneSrc(src), .tThreeSrc(src), .tOneUnderflow(ufl[0]), .tTwoUnderflow(ufl[1]),
		.tThreeUnderflow(ufl[2]), .measDone(measDone), .tFourSrcA(src), .tFourSrcB(src),
		.tOneCountPulse(p1), .tThreeCountPulse(p3), .tFourUnderflow(p4), .flagAck(flagAck),
		.reqFlags(reqFlags));
	tssp_pin_partner i_pins (.srcA(pinASrc), .srcB(pinBSrc), .outA(aOut), .oeA(aOe),
		.outB(bOut), .oeB(bOe), .pinA(pinA), .pinB(pinB));

	// ----------------------------------------------------------------
	// Clock, count source and pulse counters
	// ----------------------------------------------------------------
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// The shared count source has a period of four clocks.
	always @(posedge clk) begin
		div <= div + 2'h1;
		if (div[0]) src <= ~src;
	end
	// Counting on the falling edge keeps clear of the task updates.
	always @(negedge clk) begin
		if (p1 === 1'b1) nP[0]++;
		if (p3 === 1'b1) nP[1]++;
		if (p4 === 1'b1) nP[2]++;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task print_verdict;
		$display("Mismatches %0d, compares %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic fail;
		n_errors++;
		print_verdict();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 0;
			if (wready === 1'b1) wvalid <= 0;
			if (bvalid === 1'b1) break;
		end
		if (k == 50) fail();
		rr = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 0;
			if (rvalid === 1'b1) break;
		end
		if (k == 50) fail();
		rv = rdata;
		rr = rresp;
		rready <= 0;
	endtask
	task automatic pul(input int b);
		ufl[b] <= 1;
		@(posedge clk);
		ufl[b] <= 0;
		cyc(3);
	endtask
	task automatic meas(output int hi, output int lo);
		int k;
		hi = 0;
		lo = 0;
		for (k = 0; k < 200 && pinB !== 1'b1; k++) @(posedge clk);
		if (k == 200) fail();
		for (k = 0; k < 200 && pinB === 1'b1; k++) begin
			@(posedge clk);
			hi++;
		end
		if (k == 200) fail();
		for (k = 0; k < 200 && pinB !== 1'b1; k++) begin
			@(posedge clk);
			lo++;
		end
		if (k == 200) fail();
	endtask
	task automatic highs(input int n, output int hi);
		hi = 0;
		repeat (n) begin
			@(posedge clk);
			if (pinB === 1'b1) hi++;
		end
	endtask
	task automatic syn(input int k);
		logic [7:0] ic, tc;
		ic = k ? `TSSP_OFF_IRQ_CTRL_B : `TSSP_OFF_IRQ_CTRL_A;
		tc = k ? `TSSP_OFF_T_THREE_CTRL : `TSSP_OFF_T_ONE_CTRL;
		wr(ic, 32'h5);
		wr(tc, 32'hc);
		nP[k] = 0;
		cyc(20);
		chk("gated", nP[k], 0);
		ext[k] <= 1;
		cyc(6);
		ext[k] <= 0;
		nP[k] = 0;
		cyc(20);
		chk("counting", nP[k], 5);
		rd(`TSSP_OFF_STATUS);
		chk("sync set", rv[k], 1'b1);
		pul(2 * k);
		rd(tc);
		chk("auto stop", rv, 32'h4);
		nP[k] = 0;
		cyc(20);
		chk("stopped", nP[k], 0);
		chk("flag", reqFlags[2*k], 1'b1);
		flagAck[2*k] <= 1;
		@(posedge clk);
		flagAck[2*k] <= 0;
		cyc(2);
		chk("ack", reqFlags[2*k], 1'b0);
		wr(tc, 32'h0);
		wr(ic, 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, measDone, src, pinASrc} <= 0;
		{pinBSrc, awaddr, araddr, wdata, flagAck, ufl, ext, div} <= 0;
		nP[0] = 0;
		nP[1] = 0;
		cyc(2);
		rst_n <= 1;
		for (i = 0; i < 11; i++) begin
			rd(8'(i * 4));
			chk("reset", rv, (i == 7 || i == 8) ? 32'hff : (i == 10) ? 32'hff04 : 32'h0);
			chk("rresp", rr, `TSSP_RESP_OKAY);
		end
		rd(8'h2c);
		chk("unmapped", {rv[29:0], rr}, {30'h0, `TSSP_RESP_SLVERR});
		wr(8'h02, 32'h1);
		chk("unaligned", rr, `TSSP_RESP_SLVERR);
		syn(0);
		syn(1);
		wr(`TSSP_OFF_T_ONE_CTRL, 32'h5);
		for (i = 0; i < 2; i++) begin
			wr(`TSSP_OFF_PIN_CTRL, i ? 32'h4 : 32'h0);
			nP[0] = 0;
			pinASrc <= 1;
			cyc(8);
			chk("rise", nP[0], i ? 0 : 1);
			pinASrc <= 0;
			cyc(8);
			chk("fall", nP[0], 1);
		end
		wr(`TSSP_OFF_PIN_CTRL, 32'h1);
		cyc(1);
		chk("pin A oe", aOe, 1'b1);
		rv[0] = aOut;
		pul(0);
		chk("t1 half", aOut, !rv[0]);
		pul(1);
		chk("t2 unused", aOut, !rv[0]);
		wr(`TSSP_OFF_T_ONE_CTRL, 32'h6);
		pul(1);
		chk("t2 half", aOut, rv[0]);
		wr(`TSSP_OFF_PIN_CTRL, 32'h0);
		wr(`TSSP_OFF_REQ_FLAGS, 32'hf);
		chk("w1c", reqFlags, 4'h0);
		wr(`TSSP_OFF_PERIOD_MEAS, 32'h4);
		pul(0);
		chk("meas uf", reqFlags[0], 1'b0);
		measDone <= 1;
		@(posedge clk);
		measDone <= 0;
		cyc(2);
		chk("meas done", reqFlags[0], 1'b1);
		wr(`TSSP_OFF_PERIOD_MEAS, 32'h0);
		wr(`TSSP_OFF_T_ONE_CTRL, 32'h0);
		// High reload stays nonzero whenever the extension is on.
		wr(`TSSP_OFF_LOW_RELOAD, 32'h3);
		wr(`TSSP_OFF_HIGH_RELOAD, 32'h2);
		wr(`TSSP_OFF_T_FOUR_CTRL, 32'he);
		cyc(1);
		chk("pin B oe", bOe, 1'b1);
		meas(h, l);
		meas(h, l);
		chk("ext high", h, 14);
		chk("ext low", l, 16);
		chk("t4 flag", reqFlags[3], 1'b1);
		wr(`TSSP_OFF_T_FOUR_CTRL, 32'ha);
		meas(h, l);
		nP[2] = 0;
		meas(h, l);
		chk("high", h, 12);
		chk("t4 uf", nP[2], 2);
		chk("low", l, 16);
		meas(h, l);
		// Stopping a few clocks after the rise keeps clear of an underflow.
		rv = $time;
		wr(`TSSP_OFF_T_FOUR_CTRL, 32'h8);
		for (i = 0; i < 100 && pinB === 1'b1; i++) @(posedge clk);
		if (i == 100) fail();
		chk("stop high", ($time - rv) / 8, 12);
		nP[2] = 0;
		highs(60, h);
		chk("stopped", h, 0);
		chk("t4 idle", nP[2], 0);
		wr(`TSSP_OFF_T_FOUR_CTRL, 32'ha);
		wr(`TSSP_OFF_T_THREE_CTRL, 32'h4);
		wr(`TSSP_OFF_PIN_CTRL, 32'h2);
		pul(2);
		rd(`TSSP_OFF_STATUS);
		chk("invalid", rv[2], 1'b0);
		highs(60, h);
		chk("gated", h, 0);
		wr(`TSSP_OFF_PIN_CTRL, 32'h0);
		pul(2);
		rd(`TSSP_OFF_STATUS);
		chk("kept", rv[2], 1'b0);
		wr(`TSSP_OFF_PIN_CTRL, 32'h2);
		pul(2);
		rd(`TSSP_OFF_STATUS);
		chk("valid", rv[2], 1'b1);
		wr(`TSSP_OFF_T_THREE_CTRL, 32'h0);
		pul(2);
		rd(`TSSP_OFF_STATUS);
		chk("cancel", rv[2], 1'b1);
		print_verdict();
	end
endmodule // tssp_timer_ctrl_bench
